// ===== gateway_pkg.sv
/*
 * Shared constants and carrier types for the serial gateway mode control:
 * register offsets, reset values, timing counts, modes and line settings.
 * Assumes a single 25 MHz clock feeding every design file.
 */
`default_nettype none

package gateway_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          CLK_HZ           = 25_000_000;
	localparam int          FIXED_BAUD       = 9600;
	localparam logic [15:0] FIXED_DIV        = 16'(CLK_HZ / FIXED_BAUD);
	localparam int          TEST_TICK_MS     = 1000;
	localparam int          TEST_TICK_CYCLES = (CLK_HZ / 1000) * TEST_TICK_MS;
	localparam logic [3:0]  SETTLE_CYCLES    = 4'h4;

	// ----------------------------------------------------------------
	// switch codes
	// ----------------------------------------------------------------
	localparam logic [3:0] SEL_CONFIG = 4'hF;
	localparam logic [3:0] SEL_TEST   = 4'hE;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFF_TX       = 8'h10;
	localparam logic [7:0] OFF_RX       = 8'h14;
	localparam logic [7:0] OFF_BUS_OUT  = 8'h18;
	localparam logic [7:0] OFF_DBG_TX   = 8'h1C;
	localparam logic [7:0] OFF_BUS_IN   = 8'h20;

	localparam int IRQ_RX     = 0;
	localparam int IRQ_FRAME  = 1;
	localparam int IRQ_REJECT = 2;
	localparam int IRQ_TICK   = 3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_DATA   = 2'b00,
		MODE_CONFIG = 2'b01,
		MODE_TEST   = 2'b10
	} mode_t;

	// ctrl register bits [19:0]
	typedef struct packed {
		logic        stop_check;
		logic        parity_odd;
		logic        parity_en;
		logic        data8;
		logic [15:0] div;
	} line_cfg_t;

	typedef struct packed {
		logic [3:0] a;
		logic [3:0] b;
		logic       rs232;
	} switches_t;

	typedef struct packed {
		logic       red;
		logic       green;
		logic [3:0] code;
	} indicators_t;

	localparam line_cfg_t CFG_RESET = '{stop_check: 1'b1, parity_odd: 1'b0,
		parity_en: 1'b0, data8: 1'b1, div: FIXED_DIV};

	localparam int                    BANNER_LEN = 13;
	localparam logic [8*BANNER_LEN-1:0] BANNER   = "GATEWAY CFG\r\n";

endpackage

`default_nettype wire

// ===== serial_engine.sv
/*
 * One asynchronous serial port: transmitter and receiver with stop-bit check.
 * Assumes cfg stays stable while a character is in flight.
 */
`default_nettype none

module serial_engine import gateway_pkg::*; (
	input  wire logic      pclk,
	input  wire logic      presetn,
	input  wire line_cfg_t cfg,
	input  wire logic      tx_start,
	input  wire logic [7:0] tx_byte,
	output logic           tx_busy,
	output logic           tx,
	input  wire logic      rx,
	output logic           rx_valid,
	output logic [7:0]     rx_byte,
	output logic           frame_err
);

	typedef struct packed {
		logic [2:0]  sync;
		logic        line;
		logic        txd;
		logic        tbusy;
		logic [10:0] tsh;
		logic [3:0]  tleft;
		logic [15:0] tcnt;
		logic        rbusy;
		logic        rhalf;
		logic [3:0]  ridx;
		logic [15:0] rcnt;
		logic [9:0]  rsh;
		logic        rvalid;
		logic [7:0]  rbyte;
		logic        ferr;
	} eng_t;

	eng_t       s;
	eng_t       next_s;
	logic [7:0] d;
	logic       pbit;
	logic [3:0] last;

	always_comb begin
		next_s = s;
		next_s.rvalid = 1'b0;
		next_s.ferr = 1'b0;
		d = cfg.data8 ? tx_byte : {1'b0, tx_byte[6:0]};
		pbit = cfg.parity_en ? (^d ^ cfg.parity_odd) : 1'b1;
		last = (cfg.data8 ? 4'h8 : 4'h7) + {3'h0, cfg.parity_en};
		// ------------------------------------------------------------
		// receive line: change counts once stages two and three agree
		// ------------------------------------------------------------
		next_s.sync = {s.sync[1:0], rx};
		if (s.sync[1] == s.sync[2]) begin
			next_s.line = s.sync[2];
		end
		// ------------------------------------------------------------
		// transmitter
		// ------------------------------------------------------------
		if (!s.tbusy) begin
			next_s.txd = 1'b1;
			if (tx_start) begin
				next_s.tsh = cfg.data8 ? {1'b1, pbit, d, 1'b0} : {2'b11, pbit, d[6:0], 1'b0};
				// one extra idle bit so the far end always sees a full stop
				next_s.tleft = (cfg.data8 ? 4'hB : 4'hA) + {3'h0, cfg.parity_en}; // RULE12
				next_s.tcnt = 16'h0000;
				next_s.tbusy = 1'b1;
			end
		end else begin
			next_s.txd = s.tsh[0];
			if (s.tcnt == cfg.div - 16'h0001) begin
				next_s.tcnt = 16'h0000;
				next_s.tsh = {1'b1, s.tsh[10:1]};
				next_s.tleft = s.tleft - 4'h1;
				if (s.tleft == 4'h1) begin
					next_s.tbusy = 1'b0;
				end
			end else begin
				next_s.tcnt = s.tcnt + 16'h0001;
			end
		end
		// ------------------------------------------------------------
		// receiver
		// ------------------------------------------------------------
		if (!s.rbusy) begin
			if (!s.line) begin
				next_s.rbusy = 1'b1;
				next_s.rhalf = 1'b1;
				next_s.rcnt = 16'h0000;
				next_s.ridx = 4'h0;
			end
		end else if (s.rcnt == (s.rhalf ? {1'b0, cfg.div[15:1]} : cfg.div - 16'h0001)) begin
			next_s.rcnt = 16'h0000;
			if (s.rhalf) begin
				next_s.rhalf = 1'b0;
				if (s.line) begin
					next_s.rbusy = 1'b0;
				end
			end else begin
				next_s.rsh[s.ridx] = s.line;
				next_s.ridx = s.ridx + 4'h1;
				if (s.ridx == last) begin
					next_s.rbusy = 1'b0;
					next_s.rvalid = 1'b1;
					next_s.rbyte = cfg.data8 ? s.rsh[7:0] : {1'b0, s.rsh[6:0]};
					// stop sampled low at mid-bit means it was short
					next_s.ferr = !s.line && cfg.stop_check // RULE12 RULE13 RULE15
						&& cfg.data8 && !cfg.parity_en; // RULE14
				end
			end
		end else begin
			next_s.rcnt = s.rcnt + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{sync: 3'b111, line: 1'b1, txd: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign tx        = s.txd;
	assign tx_busy   = s.tbusy;
	assign rx_valid  = s.rvalid;
	assign rx_byte   = s.rbyte;
	assign frame_err = s.ferr;

endmodule

`default_nettype wire

// ===== serial_gateway_mode_control.sv
/*
 * Mode control of a fieldbus-to-serial gateway: power-up mode selection,
 * configuration banner, test pattern with echo, indicators, APB registers.
 * Assumes an APB master on pclk and switch pins that settle before release.
 */
`default_nettype none

// Function
// RULE1: both selectors F with RS232 at power-up selects configuration mode.
// RULE2: configuration mode forces 9600 baud, 8 data, no parity, 1 stop.
// RULE3: configuration mode sends an ASCII banner right after start.
// RULE4: configuration writes accepted only in configuration mode, rejected otherwise.
// RULE5: both selectors E with RS232 selects test mode; other switches ignored.
// RULE6: test mode sends one hex ASCII character per second, 0 to F, stored format.
// RULE7: test mode puts the test value on every fieldbus data byte.
// RULE8: test mode flashes status red/green, code indicators show test value.
// RULE9: test mode echoes every received character on its own interface.
// RULE10: fieldbus echo uses only first byte; other bytes keep their value.
// RULE11: neither configuration nor test means data exchange with stored settings.
// RULE12: receiver checks stop length; transmitter sends a long enough stop.
// RULE13: enabled check flags error indicators when stop bit is not 1 bit.
// RULE14: stop check only acts with 8 data bits and no parity.
// RULE15: stop check is a setting, enabled or disabled, enabled by default.
// RULE16: debug serial port always runs 9600 baud, 8 data, no parity, 1 stop.
// RULE17: configuration mode flashes status red; code indicators carry no meaning.
// RULE18: switches sampled once after reset; mode held until next restart.
module serial_gateway_mode_control import gateway_pkg::*; #(
	parameter int TICK_CYCLES = TEST_TICK_CYCLES,
	parameter int BUS_BYTES   = 4
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	output logic                        irq,
	input  wire logic [3:0]             mode_selector_switch_a,
	input  wire logic [3:0]             mode_selector_switch_b,
	input  wire logic                   if_select_rs232,
	input  wire logic                   ser_rx,
	output logic                        ser_tx,
	input  wire logic                   dbg_rx,
	output logic                        dbg_tx,
	input  wire logic [8*BUS_BYTES-1:0] bus_in,
	input  wire logic                   bus_in_valid,
	output logic [8*BUS_BYTES-1:0]      bus_out,
	output indicators_t                 serial_status_indicator
);

	localparam int BW = 8 * BUS_BYTES;

	typedef struct packed {
		switches_t   sw1;
		switches_t   sw2;
		switches_t   sw3;
		logic [3:0]  settle;
		logic        decided;
		mode_t       mode;
		line_cfg_t   cfg;
		logic [3:0]  irq_stat;
		logic [3:0]  irq_mask;
		logic [31:0] tick_cnt;
		logic        phase;
		logic [3:0]  test_val;
		logic [3:0]  shown;
		logic        tick_pend;
		logic [7:0]  tick_char;
		logic        echo_pend;
		logic [7:0]  echo_byte;
		logic [3:0]  banner_idx;
		logic        sw_pend;
		logic [7:0]  sw_byte;
		logic        dbg_pend;
		logic [7:0]  dbg_byte;
		logic        tx_go;
		logic [7:0]  tx_byte;
		logic        dbg_go;
		logic [7:0]  rx_data;
		logic        rx_full;
		logic [BW-1:0] bus_out;
		indicators_t led;
	} state_t;

	state_t    s;
	state_t    next_s;
	line_cfg_t line_cfg;
	logic      tx_busy;
	logic      dbg_busy;
	logic      rx_valid;
	logic [7:0] rx_byte;
	logic      frame_err;
	logic      tick;
	logic      wr;
	logic      rd;
	logic      mapped;
	logic      reject;
	logic      in_cfg;
	logic      in_test;
	logic      in_data;

	// ----------------------------------------------------------------
	// serial ports
	// ----------------------------------------------------------------
	always_comb begin
		line_cfg = s.cfg; // RULE6 RULE11
		if (in_cfg) begin
			// fixed 8N1 at 9600 whatever is stored
			line_cfg = '{stop_check: s.cfg.stop_check, parity_odd: 1'b0, // RULE2
				parity_en: 1'b0, data8: 1'b1, div: FIXED_DIV};
		end
	end

	serial_engine main_port (
		.pclk      (pclk),
		.presetn   (presetn),
		.cfg       (line_cfg),
		.tx_start  (s.tx_go),
		.tx_byte   (s.tx_byte),
		.tx_busy   (tx_busy),
		.tx        (ser_tx),
		.rx        (ser_rx),
		.rx_valid  (rx_valid),
		.rx_byte   (rx_byte),
		.frame_err (frame_err)
	);

	serial_engine debug_port (
		.pclk      (pclk),
		.presetn   (presetn),
		.cfg       (CFG_RESET), // RULE16
		.tx_start  (s.dbg_go),
		.tx_byte   (s.dbg_byte),
		.tx_busy   (dbg_busy),
		.tx        (dbg_tx),
		.rx        (dbg_rx),
		.rx_valid  (),
		.rx_byte   (),
		.frame_err ()
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.tx_go = 1'b0;
		next_s.dbg_go = 1'b0;
		in_cfg = s.decided && (s.mode == MODE_CONFIG);
		in_test = s.decided && (s.mode == MODE_TEST);
		in_data = s.decided && (s.mode == MODE_DATA);
		wr = psel && penable && pwrite;
		rd = psel && penable && !pwrite;
		mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_BUS_IN);
		reject = 1'b0;

		// switches pass three flops; decision only once after release
		next_s.sw1 = '{a: mode_selector_switch_a, b: mode_selector_switch_b,
			rs232: if_select_rs232};
		next_s.sw2 = s.sw1;
		next_s.sw3 = s.sw2;
		if (!s.decided) begin
			if (s.settle != SETTLE_CYCLES) begin
				next_s.settle = s.settle + 4'h1;
			end else if (s.sw2 == s.sw3) begin
				next_s.decided = 1'b1; // RULE18
				next_s.banner_idx = 4'h0;
				if (s.sw3.rs232 && s.sw3.a == SEL_CONFIG && s.sw3.b == SEL_CONFIG) begin
					next_s.mode = MODE_CONFIG; // RULE1
				end else if (s.sw3.rs232 && s.sw3.a == SEL_TEST && s.sw3.b == SEL_TEST) begin
					next_s.mode = MODE_TEST; // RULE5
				end else begin
					next_s.mode = MODE_DATA; // RULE11
				end
			end
		end

		// one-second tick also paces indicator flashing
		tick = (s.tick_cnt == 32'(TICK_CYCLES - 1));
		next_s.tick_cnt = tick ? 32'h0000_0000 : s.tick_cnt + 32'h0000_0001;
		if (tick) begin
			next_s.phase = ~s.phase;
		end
		if (tick && in_test) begin
			next_s.tick_pend = 1'b1; // RULE6
			next_s.tick_char = (s.test_val < 4'hA) ? 8'h30 + {4'h0, s.test_val}
				: 8'h37 + {4'h0, s.test_val};
			next_s.shown = s.test_val;
			next_s.test_val = s.test_val + 4'h1;
			for (int i = 0; i < BUS_BYTES; i++) begin
				next_s.bus_out[8*i +: 8] = {4'h0, s.test_val}; // RULE7
			end
		end

		// ------------------------------------------------------------
		// register writes; clears act before the event sets below
		// ------------------------------------------------------------
		if (wr) begin
			unique case (paddr)
				OFF_CTRL: begin
					if (in_cfg) begin
						next_s.cfg = line_cfg_t'(pwdata[19:0]); // RULE4 RULE15
					end else begin
						reject = 1'b1; // RULE4
					end
				end
				OFF_IRQ_STAT: next_s.irq_stat = s.irq_stat & ~pwdata[3:0];
				OFF_IRQ_MASK: next_s.irq_mask = pwdata[3:0];
				OFF_TX: begin
					if (in_data && !s.sw_pend) begin
						next_s.sw_pend = 1'b1;
						next_s.sw_byte = pwdata[7:0];
					end else begin
						reject = 1'b1;
					end
				end
				OFF_BUS_OUT: begin
					if (in_data) begin
						next_s.bus_out = BW'(pwdata);
					end else begin
						reject = 1'b1;
					end
				end
				OFF_DBG_TX: begin
					if (!s.dbg_pend) begin
						next_s.dbg_pend = 1'b1;
						next_s.dbg_byte = pwdata[7:0];
					end else begin
						reject = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (rd && paddr == OFF_RX) begin
			next_s.rx_full = 1'b0;
		end

		// ------------------------------------------------------------
		// transmit arbitration
		// ------------------------------------------------------------
		if (!tx_busy && !s.tx_go) begin
			if (in_cfg && s.banner_idx != 4'(BANNER_LEN)) begin
				next_s.tx_go = 1'b1; // RULE3
				next_s.tx_byte = BANNER[8*(BANNER_LEN-1-int'(s.banner_idx)) +: 8];
				next_s.banner_idx = s.banner_idx + 4'h1;
			end else if (in_test && s.tick_pend) begin
				next_s.tx_go = 1'b1; // RULE6
				next_s.tx_byte = s.tick_char;
				next_s.tick_pend = 1'b0;
			end else if (in_test && s.echo_pend) begin
				next_s.tx_go = 1'b1; // RULE9
				next_s.tx_byte = s.echo_byte;
				next_s.echo_pend = 1'b0;
			end else if (in_data && s.sw_pend) begin
				next_s.tx_go = 1'b1; // RULE11
				next_s.tx_byte = s.sw_byte;
				next_s.sw_pend = 1'b0;
			end
		end
		if (!dbg_busy && !s.dbg_go && s.dbg_pend) begin
			next_s.dbg_go = 1'b1; // RULE16
			next_s.dbg_pend = 1'b0;
		end

		// ------------------------------------------------------------
		// receive side and events; sets win over clears
		// ------------------------------------------------------------
		if (rx_valid && in_test) begin
			next_s.echo_pend = 1'b1; // RULE9
			next_s.echo_byte = rx_byte;
		end
		if (rx_valid && in_data) begin
			next_s.rx_data = rx_byte;
			next_s.rx_full = 1'b1;
			next_s.irq_stat[IRQ_RX] = 1'b1;
		end
		if (in_test && bus_in_valid) begin
			next_s.bus_out[7:0] = bus_in[7:0]; // RULE9 RULE10
		end
		if (frame_err) begin
			next_s.irq_stat[IRQ_FRAME] = 1'b1; // RULE13
		end
		if (reject || (wr && !mapped)) begin
			next_s.irq_stat[IRQ_REJECT] = 1'b1;
		end
		if (tick && in_test) begin
			next_s.irq_stat[IRQ_TICK] = 1'b1;
		end

		// ------------------------------------------------------------
		// indicators
		// ------------------------------------------------------------
		next_s.led = '{red: 1'b0, green: 1'b0, code: 4'h0};
		if (in_cfg) begin
			next_s.led.red = s.phase; // RULE17
		end else if (in_test) begin
			next_s.led = '{red: s.phase, green: ~s.phase, code: s.shown}; // RULE8
		end else if (in_data) begin
			// error stays shown until software clears the status bit
			next_s.led.green = !s.irq_stat[IRQ_FRAME];
			next_s.led.red = s.irq_stat[IRQ_FRAME]; // RULE13
			next_s.led.code = {3'h0, s.irq_stat[IRQ_FRAME]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{cfg: CFG_RESET, mode: MODE_DATA, default: '0}; // RULE15
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// bus answer and outputs
	// ----------------------------------------------------------------
	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			OFF_CTRL:     prdata = {12'h000, s.cfg};
			OFF_STATUS:   prdata = {24'h000000, s.rx_full, s.dbg_pend, s.sw_pend,
				tx_busy, 1'b0, s.decided, s.mode};
			OFF_IRQ_STAT: prdata = {28'h0000000, s.irq_stat};
			OFF_IRQ_MASK: prdata = {28'h0000000, s.irq_mask};
			OFF_RX:       prdata = {24'h000000, s.rx_data};
			OFF_BUS_OUT:  prdata = 32'(s.bus_out);
			OFF_BUS_IN:   prdata = 32'(bus_in);
			default:      prdata = 32'h0000_0000;
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && (!mapped || (pwrite && reject));
	assign irq     = |(s.irq_stat & s.irq_mask);
	assign bus_out = s.bus_out;
	assign serial_status_indicator = s.led;

endmodule

`default_nettype wire

// ===== gateway_props.sv
/*
 * Checker for the gateway mode control, bound to its top module.
 * Assumes one pclk domain, a fieldbus of at least four bytes, 9600 bit time.
 */
`default_nettype none

module gateway_props import gateway_pkg::*; #(
	parameter int BUS_BYTES = 4
) (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   irq,
	input wire logic                   ser_tx,
	input wire logic                   bus_in_valid,
	input wire logic [8*BUS_BYTES-1:0] bus_out,
	input wire indicators_t            serial_status_indicator
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// line run counters
	// ----------------------------------------------------------------
	// two cycles of slack on the bit time; reset value covers the first edge
	localparam logic [15:0] BIT_MIN = FIXED_DIV - 16'h2;
	logic [15:0] hi_run;
	logic [15:0] lo_run;
	logic        bad_addr;

	assign bad_addr = (paddr > 8'h20) || (paddr[1:0] != 2'b00);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_run <= 16'hFFFF;
			lo_run <= 16'hFFFF;
		end else begin
			hi_run <= !ser_tx ? 16'h0 : ((hi_run == 16'hFFFF) ? hi_run : hi_run + 16'h1);
			lo_run <= ser_tx ? 16'h0 : ((lo_run == 16'hFFFF) ? lo_run : lo_run + 16'h1);
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ready_always: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	a_unmapped_err: assert property (psel && penable && bad_addr |-> pslverr)
		else $error("unmapped access not refused");
	a_unmapped_zero: assert property (psel && penable && !pwrite && bad_addr |-> prdata == 32'h0)
		else $error("unmapped read returned data");
	a_stop_long: assert property ($fell(ser_tx) |-> hi_run >= BIT_MIN)
		else $error("high run on serial out shorter than a bit");
	a_start_long: assert property ($rose(ser_tx) |-> lo_run >= BIT_MIN)
		else $error("low run on serial out shorter than a bit");
	a_bytes_equal: assert property ($changed(bus_out[31:8]) |->
		bus_out[31:24] == bus_out[23:16] && bus_out[23:16] == bus_out[15:8])
		else $error("fieldbus bytes differ after pattern update");
	a_echo_low_only: assert property (bus_in_valid |=> $stable(bus_out[31:8]))
		else $error("fieldbus echo touched upper bytes");
	a_code_tracks: assert property ($changed(bus_out[31:24]) |->
		##[0:2] serial_status_indicator.code == bus_out[27:24])
		else $error("code indicators do not show test value");

	c_tx_frame: cover property ($fell(ser_tx));
	c_bus_echo: cover property (bus_in_valid);
	c_irq_rise: cover property ($rose(irq));
endmodule

bind serial_gateway_mode_control gateway_props #(.BUS_BYTES(BUS_BYTES)) props_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.ser_tx(ser_tx), .bus_in_valid(bus_in_valid), .bus_out(bus_out),
	.serial_status_indicator(serial_status_indicator)
);

`default_nettype wire

// ===== serial_peer.sv
/*
 * Serial peer: an external 8N1 terminal on the gateway's serial pins.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`default_nettype none

module serial_peer #(
	parameter int BIT_CYCLES = 2604
) (
	input  wire logic clk,
	input  wire logic line_in,
	output var logic  line_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// frame tasks
	// ----------------------------------------------------------------
	initial line_out = 1'b1;

	// a low stop bit provokes a framing fault on purpose
	task automatic send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_out <= f[i];
			repeat (BIT_CYCLES) @(posedge clk);
		end
		line_out <= 1'b1;
	endtask

	task automatic recv(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		while (line_in !== 1'b0 && n < 40000) begin
			@(posedge clk);
			n++;
		end
		repeat (BIT_CYCLES / 2) @(posedge clk);
		ok = (line_in === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clk);
			b[i] = line_in;
		end
		repeat (BIT_CYCLES) @(posedge clk);
		ok = ok && (line_in === 1'b1);
	endtask
endmodule

`default_nettype wire

// ===== serial_gateway_mode_control_tb.sv
/*
 * Self-checking bench for the gateway mode control: config, test, data modes.
 * Assumes the serial peer on ser_tx/ser_rx and the checker bound to the top.
 */
`default_nettype none

module serial_gateway_mode_control_tb import gateway_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TICK = 3000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic        rs232, ser_rx, ser_tx, dbg_tx, bus_in_valid, er, ok, r;
	logic [7:0]  paddr, ch;
	logic [31:0] pwdata, prdata, bus_in, bus_out, rd;
	logic [3:0]  sw_a, sw_b, c;
	indicators_t ind;
	int          bad_count, checks, n;

	serial_gateway_mode_control #(.TICK_CYCLES(TICK), .BUS_BYTES(4)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq),
		.mode_selector_switch_a(sw_a), .mode_selector_switch_b(sw_b),
		.if_select_rs232(rs232), .ser_rx(ser_rx), .ser_tx(ser_tx),
		.dbg_rx(1'b1), .dbg_tx(dbg_tx), .bus_in(bus_in), .bus_in_valid(bus_in_valid),
		.bus_out(bus_out), .serial_status_indicator(ind)
	);

	serial_peer #(.BIT_CYCLES(int'(FIXED_DIV))) peer_u (
		.clk(pclk), .line_in(ser_tx), .line_out(ser_rx)
	);

	// listens on the debug port only; its own line is left idle
	serial_peer #(.BIT_CYCLES(int'(FIXED_DIV))) dbg_u (
		.clk(pclk), .line_in(dbg_tx), .line_out()
	);

	// ----------------------------------------------------------------
	// bench tasks
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			chk(32'h0, 32'h1);
	endtask

	// switches settle with reset held, so the decision sees them stable
	task automatic start(input logic [3:0] a, input logic [3:0] b, input logic s);
		presetn <= 1'b0;
		sw_a    <= a;
		sw_b    <= b;
		rs232   <= s;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	task automatic next_tick();
		logic [3:0] p;
		p = ind.code;
		n = 0;
		while (ind.code === p && n < 2 * TICK) begin
			@(posedge pclk);
			n++;
		end
		@(negedge pclk);
	endtask

	task automatic final_report();
		$display("checks %0d, bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (95000) @(posedge pclk);
		bad_count++;
		final_report();
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		bus_in = 32'h0;
		bus_in_valid = 1'b0;
		sw_a = 4'h0;
		sw_b = 4'h0;
		rs232 = 1'b0;
		bad_count = 0;
		checks = 0;
		@(posedge pclk);
		start(4'hF, 4'hF, 1'b1);
		peer_u.recv(ch, ok);
		chk({23'h0, ok, ch}, 32'h0000_0147);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h7, 32'h5);
		chk(32'(ind.green), 32'h0);
		apb(1'b1, OFF_CTRL, 32'h0001_0A2C);
		chk(32'(er), 32'h0);

		// test mode; switches moved after the decision must not matter
		@(posedge pclk);
		start(4'hE, 4'hE, 1'b1);
		repeat (20) @(posedge pclk);
		sw_a  <= 4'h0;
		rs232 <= 1'b0;
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h7, 32'h6);
		apb(1'b1, OFF_CTRL, 32'h0009_0A2C);
		chk(32'(er), 32'h1);
		peer_u.recv(ch, ok);
		chk({23'h0, ok, ch}, 32'h0000_0130);
		next_tick();
		c = ind.code;
		r = ind.red;
		chk(bus_out, {4{4'h0, c}});
		chk(32'(ind.red ^ ind.green), 32'h1);
		@(posedge pclk);
		bus_in       <= 32'hAABB_CC5A;
		bus_in_valid <= 1'b1;
		@(posedge pclk);
		bus_in_valid <= 1'b0;
		@(negedge pclk);
		chk(bus_out, {{3{4'h0, c}}, 8'h5A});
		next_tick();
		c = c + 4'h1;
		chk(32'(ind.code), 32'(c));
		chk(32'(ind.red), 32'(!r));
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h7, 32'h6);

		// selectors at F without the serial interface choice: data mode
		@(posedge pclk);
		start(4'hF, 4'hF, 1'b0);
		repeat (20) @(posedge pclk);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h7, 32'h4);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd & 32'h000F_FFFF, 32'h0009_0A2C);
		apb(1'b1, OFF_CTRL, 32'h0);
		chk(32'(er), 32'h1);
		chk(32'(irq), 32'h0);
		apb(1'b0, 8'h24, 32'h0);
		chk(32'(er), 32'h1);
		apb(1'b1, OFF_IRQ_MASK, 32'h0000_0002);
		apb(1'b1, OFF_DBG_TX, 32'h0000_003C);
		@(posedge pclk);
		// debug frame runs alongside the faulty frame to save run time
		fork
			peer_u.send(8'hA5, 1'b0);
			dbg_u.recv(ch, ok);
		join
		chk({23'h0, ok, ch}, 32'h0000_013C);
		chk(32'(irq), 32'h1);
		chk(32'(ind), 32'h0000_0021);
		apb(1'b0, OFF_IRQ_STAT, 32'h0);
		chk(rd & 32'h3, 32'h3);
		apb(1'b0, OFF_RX, 32'h0);
		chk(rd & 32'hFF, 32'hA5);
		apb(1'b1, OFF_IRQ_STAT, 32'h0000_000F);
		@(negedge pclk);
		chk(32'(irq), 32'h0);
		final_report();
	end
endmodule

`default_nettype wire
